// ### src/spimsp_port.sv
`timescale 1ns/10ps
// ****************************************************************
// Master and slave serial port, system clock side
// ****************************************************************
module spimsp_port (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         spi_control_reg_wr,
    input  wire logic [7:0]                   spi_control_reg_wdata,
    input  wire logic                         spi_status_reg_rd,
    input  wire logic                         spi_data_reg_wr,
    input  wire logic [7:0]                   spi_data_reg_wdata,
    input  wire logic                         spi_data_reg_rd,
    output spimsp_pkg::spimsp_ctrl_type       spi_control_reg_q,
    output logic [7:0]                        spi_status_reg_q,
    output logic [7:0]                        spi_data_reg_q,
    output logic                              done_irq,
    output logic                              fault_irq,
    output logic                              busy,
    output logic                              ss_gp_free,
    input  wire logic                         ss_n_i,
    input  wire logic                         sck_i,
    output logic                              sck_o,
    output logic                              sck_oe_n,
    input  wire logic                         mosi_i,
    output logic                              mosi_o,
    output logic                              mosi_oe_n,
    input  wire logic                         miso_i,
    output logic                              miso_o,
    output logic                              miso_oe_n
);
    spimsp_pkg::spimsp_core_type q;
    spimsp_pkg::spimsp_core_type d;

    logic       [2:0] rate;
    logic       [6:0] half_last;
    logic             rate_ok;
    logic             m_event;
    logic             m_finish;
    logic             fault_now;
    logic             slave_evt;
    logic             slave_sel_pin;
    logic             slave_sel_sync;
    logic             ignore_ss;
    logic             sck_link;
    logic             frame_rst;
    logic             link_miso;
    logic       [7:0] link_rx;
    logic             link_tgl;
    logic             start_ok;

    // ****************************************************************
    // Decoded control terms
    // ****************************************************************
    // rate divider select.
    assign rate      = {q.ctrl.rate_select_bit2, q.ctrl.rate_select_bit1, q.ctrl.rate_select_bit0};
    assign rate_ok   = (rate != spimsp_pkg::RATE_NONE_LO) && (rate != spimsp_pkg::RATE_NONE_HI);
    assign half_last = (spimsp_pkg::DIV_ONE << rate) - spimsp_pkg::DIV_ONE;
    assign m_event   = (q.mstate == spimsp_pkg::MS_RUN) && (q.div == half_last);
    assign m_finish  = m_event && (q.edge_idx == spimsp_pkg::EDGE_END);
    assign start_ok  = spi_data_reg_wr && q.ctrl.master_select_bit && q.ctrl.module_enable_bit
                       && rate_ok && (q.mstate == spimsp_pkg::MS_IDLE);

    assign fault_now = q.ctrl.master_select_bit && q.ctrl.module_enable_bit
                       && !q.ctrl.select_disable_bit && !q.ss_s2;

    assign ignore_ss      = q.ctrl.select_disable_bit && q.ctrl.sample_phase_bit;
    assign slave_sel_pin  = q.ctrl.module_enable_bit && !q.ctrl.master_select_bit && (!ss_n_i || ignore_ss);
    assign slave_sel_sync = q.ctrl.module_enable_bit && !q.ctrl.master_select_bit && (!q.ss_s2 || ignore_ss);
    assign slave_evt      = (q.dn_s2 != q.dn_s3) && !q.ctrl.master_select_bit;

    assign ss_gp_free = q.ctrl.module_enable_bit && q.ctrl.select_disable_bit
                        && (q.ctrl.master_select_bit || q.ctrl.sample_phase_bit);

    // ****************************************************************
    // Link side hookup
    // ****************************************************************
    // The link clock is the pin turned so that the sampling edge rises.
    // Polarity and phase may only change while disabled, which holds the
    // shifter in reset, so the inversion never glitches a live frame.
    // edge selection.
    assign sck_link  = sck_i ^ (q.ctrl.clock_idle_level_bit ^ q.ctrl.sample_phase_bit);
    assign frame_rst = rst || !slave_sel_pin;

    spimsp_link u_link (
        .sck_link (sck_link),
        .rst      (rst),
        .frame_rst(frame_rst),
        .mosi_pin (mosi_i),
        .tx_hold  (q.tx_hold),
        .miso_bit (link_miso),
        .rx_byte  (link_rx),
        .done_tgl (link_tgl)
    );

    // ****************************************************************
    // Pins and software view
    // ****************************************************************
    // idle levels when disabled.
    assign sck_o     = (q.mstate == spimsp_pkg::MS_RUN) ? q.sck : q.ctrl.clock_idle_level_bit;
    assign mosi_o    = q.ctrl.module_enable_bit ? q.tx_sh[7] : spimsp_pkg::MOSI_IDLE;
    assign sck_oe_n  = !(q.ctrl.module_enable_bit && q.ctrl.master_select_bit);
    assign mosi_oe_n = !(q.ctrl.module_enable_bit && q.ctrl.master_select_bit);
    assign miso_o    = link_miso;
    assign miso_oe_n = !slave_sel_sync;

    assign spi_control_reg_q = q.ctrl;
    assign spi_data_reg_q    = q.rx_data;
    assign done_irq          = q.transfer_done_flag;
    assign fault_irq         = q.mode_fault_flag && !q.ctrl.select_disable_bit;
    assign busy              = (q.mstate == spimsp_pkg::MS_RUN);

    always_comb begin
        spi_status_reg_q = 8'h00;
        spi_status_reg_q[spimsp_pkg::STAT_DONE_POS]  = q.transfer_done_flag;
        spi_status_reg_q[spimsp_pkg::STAT_WCOL_POS]  = q.wcol;
        spi_status_reg_q[spimsp_pkg::STAT_FAULT_POS] = q.mode_fault_flag;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Clears are applied first and every hardware set afterwards, so a set
    // in the same cycle as a clear always wins.
    always_comb begin
        logic [7:0] rx_next;
        rx_next = q.rx_sh;
        d = q;
        // Pin synchronisers; only the later stages are ever read (s2, plus dn_s3 for the toggle edge).
        d.ss_s1   = ss_n_i;
        d.ss_s2   = q.ss_s1;
        d.miso_s1 = miso_i;
        d.miso_s2 = q.miso_s1;
        d.dn_s1   = link_tgl;
        d.dn_s2   = q.dn_s1;
        d.dn_s3   = q.dn_s2;

        // Arming reads of the status register.
        if (spi_status_reg_rd) begin
            d.done_armed  = q.transfer_done_flag;
            d.fault_armed = q.mode_fault_flag;
            d.wcol_armed  = q.wcol;
        end
        if (spi_data_reg_rd && q.done_armed) begin
            d.transfer_done_flag = 1'b0;
            d.done_armed         = 1'b0;
        end
        if ((spi_data_reg_rd || spi_data_reg_wr) && q.wcol_armed) begin
            d.wcol       = 1'b0;
            d.wcol_armed = 1'b0;
        end
        if (spi_control_reg_wr) begin
            d.ctrl = spimsp_pkg::spimsp_ctrl_type'(spi_control_reg_wdata);
            if (q.fault_armed) begin
                d.mode_fault_flag = 1'b0;
            end
            d.fault_armed = 1'b0;
        end

        // Slave transmit byte. A write that lands while a frame runs misses
        // it, because the shifter took the byte at its first edge.
        if (spi_data_reg_wr && !q.ctrl.master_select_bit) begin
            d.tx_hold = spi_data_reg_wdata;
        end

        if (start_ok) begin
            d.tx_sh    = spi_data_reg_wdata;
            d.mstate   = spimsp_pkg::MS_RUN;
            d.div      = 7'h00;
            d.edge_idx = 5'h00;
            d.toggles  = 5'h00;
            d.sck      = q.ctrl.clock_idle_level_bit;
        end else if (spi_data_reg_wr && q.mstate == spimsp_pkg::MS_RUN) begin
            d.wcol = 1'b1;
        end

        if (q.mstate == spimsp_pkg::MS_RUN) begin
            d.div = q.div + 7'h01;
            if (m_event) begin
                d.div      = 7'h00;
                d.edge_idx = q.edge_idx + 5'h01;
                if (q.edge_idx != spimsp_pkg::EDGE_END) begin
                    d.sck     = ~q.sck;
                    d.toggles = q.toggles + 5'h01;
                end
                // The input is taken one half period after its edge, which
                // covers the two-stage synchroniser delay at the top rate.
                // master receive path.
                if (q.edge_idx != 5'h00 && ((q.edge_idx[0] ^ 1'b1) == q.ctrl.sample_phase_bit)) begin
                    rx_next = {q.rx_sh[6:0], q.miso_s2};
                end
                d.rx_sh = rx_next;
                if (q.edge_idx != 5'h00 && q.edge_idx != spimsp_pkg::EDGE_END
                    && q.edge_idx[0] != q.ctrl.sample_phase_bit) begin
                    d.tx_sh = {q.tx_sh[6:0], 1'b0};
                end
                if (m_finish) begin
                    d.mstate             = spimsp_pkg::MS_IDLE;
                    d.rx_data            = rx_next;
                    d.transfer_done_flag = 1'b1;
                end
            end
        end

        if (slave_evt) begin
            d.rx_data            = link_rx;
            d.transfer_done_flag = 1'b1;
            // After a byte the one shift register holds what came in, so
            // that is what goes out next unless software writes again.
            // late write resends old.
            d.tx_hold = spi_data_reg_wr ? spi_data_reg_wdata : link_rx;
        end

        if (fault_now) begin
            d.mode_fault_flag             = 1'b1;
            d.ctrl.module_enable_bit      = 1'b0;
            d.ctrl.master_select_bit      = 1'b0;
        end
        // A disabled port abandons any byte in flight.
        if (!d.ctrl.module_enable_bit || !d.ctrl.master_select_bit) begin
            d.mstate = spimsp_pkg::MS_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q      <= '0;
            q.ctrl <= spimsp_pkg::spimsp_ctrl_type'(spimsp_pkg::CTRL_RESET);
            q.ss_s1 <= 1'b1;
            q.ss_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_fault_entry: assert property (@(posedge clk) disable iff (rst)
        fault_now |=> (q.mode_fault_flag && !q.ctrl.module_enable_bit && !q.ctrl.master_select_bit))
        else $error("Mode fault did not disable the master.");

    a_gp_no_fault: assert property (@(posedge clk) disable iff (rst)
        (q.ctrl.master_select_bit && q.ctrl.select_disable_bit && !q.mode_fault_flag) |=> !q.mode_fault_flag)
        else $error("Fault flagged with select disabled.");

    a_fault_kept: assert property (@(posedge clk) disable iff (rst)
        (q.mode_fault_flag && !q.fault_armed && spi_control_reg_wr) |=> q.mode_fault_flag)
        else $error("Control write cleared fault without status read.");

    a_fault_clear: assert property (@(posedge clk) disable iff (rst)
        (q.mode_fault_flag && q.fault_armed && spi_control_reg_wr && !fault_now) |=> !q.mode_fault_flag)
        else $error("Fault clear sequence failed.");

    a_miso_release: assert property (@(posedge clk) disable iff (rst)
        (q.ss_s2 && !ignore_ss) |-> miso_oe_n)
        else $error("MISO driven while not selected.");

    a_no_rate_idle: assert property (@(posedge clk) disable iff (rst)
        (q.mstate == spimsp_pkg::MS_IDLE && !rate_ok) |=> q.mstate == spimsp_pkg::MS_IDLE)
        else $error("Transfer started with no rate generator.");

    a_start_load: assert property (@(posedge clk) disable iff (rst)
        start_ok |=> ((q.mstate == spimsp_pkg::MS_RUN && q.tx_sh == $past(spi_data_reg_wdata))
                      || !q.ctrl.module_enable_bit || !q.ctrl.master_select_bit))
        else $error("Data write did not start the master.");

    a_done_copy: assert property (@(posedge clk) disable iff (rst)
        m_finish |=> (q.transfer_done_flag && q.rx_data == q.rx_sh && q.mstate == spimsp_pkg::MS_IDLE))
        else $error("Master end did not store byte and flag.");

    a_eight_clocks: assert property (@(posedge clk) disable iff (rst)
        m_finish |-> (q.toggles == spimsp_pkg::EDGE_END && q.sck == q.ctrl.clock_idle_level_bit))
        else $error("Master clock count wrong.");

    a_done_clear: assert property (@(posedge clk) disable iff (rst)
        (q.transfer_done_flag && q.done_armed && spi_data_reg_rd && !m_finish && !slave_evt) |=> !q.transfer_done_flag)
        else $error("Done flag clear sequence failed.");

    a_idle_off: assert property (@(posedge clk) disable iff (rst)
        !q.ctrl.module_enable_bit |-> (sck_o == q.ctrl.clock_idle_level_bit && mosi_o == spimsp_pkg::MOSI_IDLE && !busy))
        else $error("Disabled port not idle.");

    a_slave_store: assert property (@(posedge clk) disable iff (rst)
        slave_evt |=> (q.transfer_done_flag && q.rx_data == $past(link_rx)))
        else $error("Slave byte not stored.");

    a_late_resend: assert property (@(posedge clk) disable iff (rst)
        (slave_evt && !spi_data_reg_wr) |=> q.tx_hold == $past(link_rx))
        else $error("Slave did not keep the received byte for resend.");

endmodule : spimsp_port

// ### src/spimsp_pkg.sv
package spimsp_pkg;

    // ****************************************************************
    // Control and status layout
    // ****************************************************************
    typedef struct packed {
        logic rate_select_bit2;
        logic module_enable_bit;
        logic select_disable_bit;
        logic master_select_bit;
        logic clock_idle_level_bit;
        logic sample_phase_bit;
        logic rate_select_bit1;
        logic rate_select_bit0;
    } spimsp_ctrl_type;

    localparam logic [7:0] CTRL_RESET     = 8'h14;
    localparam int         STAT_DONE_POS  = 7;
    localparam int         STAT_WCOL_POS  = 6;
    localparam int         STAT_FAULT_POS = 4;

    // ****************************************************************
    // Timing and framing constants
    // ****************************************************************
    localparam logic [2:0] RATE_NONE_LO = 3'h0;
    localparam logic [2:0] RATE_NONE_HI = 3'h7;
    localparam logic [6:0] DIV_ONE      = 7'h01;
    localparam logic [4:0] EDGE_END     = 5'h10;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic       MOSI_IDLE    = 1'b1;

    typedef enum logic {MS_IDLE, MS_RUN} spimsp_mstate_type;

    // ****************************************************************
    // State of the system clock side
    // ****************************************************************
    typedef struct packed {
        spimsp_ctrl_type   ctrl;
        logic              ss_s1;
        logic              ss_s2;
        logic              miso_s1;
        logic              miso_s2;
        logic              dn_s1;
        logic              dn_s2;
        logic              dn_s3;
        spimsp_mstate_type mstate;
        logic [6:0]        div;
        logic [4:0]        edge_idx;
        logic [4:0]        toggles;
        logic              sck;
        logic [7:0]        tx_sh;
        logic [7:0]        rx_sh;
        logic [7:0]        rx_data;
        logic [7:0]        tx_hold;
        logic              transfer_done_flag;
        logic              done_armed;
        logic              mode_fault_flag;
        logic              fault_armed;
        logic              wcol;
        logic              wcol_armed;
    } spimsp_core_type;

    // ****************************************************************
    // State of the link clock side
    // ****************************************************************
    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] sh;
    } spimsp_lframe_type;

    typedef struct packed {
        logic [7:0] rx;
        logic       tgl;
    } spimsp_lhold_type;

endpackage : spimsp_pkg

// ### src/spimsp_link.sv
`timescale 1ns/10ps
// ****************************************************************
// Slave shifter on the external serial clock
// ****************************************************************
module spimsp_link (
    input  wire logic       sck_link,
    input  wire logic       rst,
    input  wire logic       frame_rst,
    input  wire logic       mosi_pin,
    input  wire logic [7:0] tx_hold,
    output logic            miso_bit,
    output logic [7:0]      rx_byte,
    output logic            done_tgl
);
    spimsp_pkg::spimsp_lframe_type f_q;
    spimsp_pkg::spimsp_lframe_type f_d;
    spimsp_pkg::spimsp_lhold_type  h_q;
    spimsp_pkg::spimsp_lhold_type  h_d;

    // The rising edge of sck_link is always the sampling edge. Before the
    // first edge the MSB comes straight from the holding byte, so it is
    // valid ahead of the first edge as the zero-phase format needs.
    // early MSB drive.
    assign miso_bit = (f_q.cnt == 3'h0) ? tx_hold[7] : f_q.sh[7];
    assign rx_byte  = h_q.rx;
    assign done_tgl = h_q.tgl;

    // One shift register serves both directions, MSB first.
    // full duplex shift.
    always_comb begin
        f_d = f_q;
        h_d = h_q;
        if (f_q.cnt == 3'h0) begin
            f_d.sh = {tx_hold[6:0], mosi_pin};
        end else begin
            f_d.sh = {f_q.sh[6:0], mosi_pin};
        end
        f_d.cnt = f_q.cnt + 3'h1;
        if (f_q.cnt == spimsp_pkg::BIT_LAST) begin
            h_d.rx  = {f_q.sh[6:0], mosi_pin};
            h_d.tgl = ~h_q.tgl;
        end
    end

    // The frame part restarts whenever select rises, because the link clock
    // stops outside frames; with phase one and select disabled the bit
    // counter simply wraps from byte to byte.
    // byte framing.
    always_ff @(posedge sck_link or posedge frame_rst) begin
        if (frame_rst) begin
            f_q <= '0;
        end else begin
            f_q <= f_d;
        end
    end

    // The completion toggle must survive the frame reset, or an event that
    // ends just before select rises would be lost.
    always_ff @(posedge sck_link or posedge rst) begin
        if (rst) begin
            h_q <= '0;
        end else begin
            h_q <= h_d;
        end
    end

endmodule : spimsp_link

// ### tb/spimsp_far.sv
`timescale 1ns/10ps
// ****
// Slave model on the far end of the master link
// ****
module spimsp_far (
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    input  wire logic       pol,
    input  wire logic       pha,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic [7:0]      rx
);
    logic [7:0] sh;
    logic [3:0] n;
    wire        smp = sck ^ pol ^ pha;
    always @(negedge ss_n) begin
        sh = tx;
        n = 4'h0;
    end
    always @(posedge smp) begin
        if (!ss_n) begin
            rx = {rx[6:0], mosi};
            n = n + 4'h1;
        end
    end
    // Shift on the other edge, never before the first sample.
    always @(negedge smp) begin
        if (!ss_n && n != 4'h0) begin
            sh = {sh[6:0], 1'b0};
        end
    end
    assign miso = ss_n ? ~sh[7] : sh[7];
endmodule : spimsp_far

// ### tb/tb_top.sv
`timescale 1ns/10ps
// ****
// Bench of the serial port
// ****
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cw = 1'b0, sr = 1'b0, dw = 1'b0, dr = 1'b0, flt, gpf, dirq;
    logic [7:0]  cd = 8'h00, dd = 8'h00, ftx = 8'h00, frx, st, dat, cap;
    logic        ss_t = 1'b1, fss = 1'b1, sck_t = 1'b0, mosi_t = 1'b0, pol_t, pha_t;
    logic        sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_f, miso_o, miso_oe_n, busy;
    logic [31:0] seed = 32'h00001FD4;
    int          mismatches = 0, n_compared = 0, edges = 0;
    spimsp_pkg::spimsp_ctrl_type ctl_q;
    always #5 clk = ~clk;
    // Each change of the driven clock is one edge.
    always @(sck_o) edges = edges + 1;
    spimsp_port dut_u (.clk(clk), .rst(rst), .spi_control_reg_wr(cw), .spi_control_reg_wdata(cd),
        .spi_status_reg_rd(sr), .spi_data_reg_wr(dw), .spi_data_reg_wdata(dd), .spi_data_reg_rd(dr),
        .spi_control_reg_q(ctl_q), .spi_status_reg_q(st), .spi_data_reg_q(dat), .done_irq(dirq),
        .fault_irq(flt), .busy(busy), .ss_gp_free(gpf), .ss_n_i(ss_t), .sck_i(sck_t), .sck_o(sck_o),
        .sck_oe_n(sck_oe_n), .mosi_i(mosi_t), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n),
        .miso_i(miso_f), .miso_o(miso_o), .miso_oe_n(miso_oe_n));
    spimsp_far far_u (.sck(sck_o), .ss_n(fss), .mosi(mosi_o), .pol(pol_t), .pha(pha_t), .tx(ftx),
        .miso(miso_f), .rx(frx));
    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [7:0] ctl(logic en, logic sd, logic ms, logic p, logic h, logic [2:0] r);
        return {r[2], en, sd, ms, p, h, r[1:0]};
    endfunction : ctl
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One strobe pulse: 0 control write, 1 status read, 2 data write, 3 data read.
    task automatic pulse(int k, logic [7:0] v);
        @(posedge clk);
        cd <= v;
        dd <= v;
        {cw, sr, dw, dr} <= 4'h8 >> k;
        @(posedge clk);
        {cw, sr, dw, dr} <= 4'h0;
    endtask : pulse
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic mxfer(logic [2:0] r, logic p, logic h, logic [7:0] b, logic [7:0] t);
        int cyc;
        {pol_t, pha_t, ftx} = {p, h, t};
        pulse(0, ctl(1'b0, 1'b0, 1'b1, p, h, r));
        pulse(0, ctl(1'b1, 1'b0, 1'b1, p, h, r));
        fss <= 1'b0;
        edges = 0;
        pulse(2, b);
        #1 chk("busy", {busy, sck_oe_n, mosi_oe_n}, 16'h0004);
        // A write while busy only flags a collision; the byte runs on.
        pulse(2, ~b);
        #1 chk("collision", st & 8'h40, 16'h0040);
        for (cyc = 0; cyc < 3000 && busy !== 1'b0; cyc++) @(posedge clk) #1;
        // Seventeen half periods of 2**r cycles, less the two of the collision write.
        chk("period", cyc[15:0], (16'h0011 << r) - 16'h0002);
        repeat (3) @(posedge clk);
        #1 chk("edges", edges[7:0], 8'h10);
        chk("idle", sck_o, p);
        chk("master rx", dat, t);
        chk("far rx", frx, b);
        chk("done", {st[7], dirq}, 16'h0003);
        pulse(1, 8'h00);
        pulse(3, 8'h00);
        #1 chk("done clear", st & 8'hC0, 16'h0000);
        fss <= 1'b1;
    endtask : mxfer
    // Link clock of 12 ns driven only within the frame. The shifter runs on
    // that clock itself, so only one completion toggle per byte crosses.
    // link clock kept to frames.
    task automatic sxfer(logic p, logic h, logic sd, logic w, logic [7:0] b, logic [7:0] t, logic [7:0] e);
        sck_t <= p;
        pulse(0, ctl(1'b0, sd, 1'b0, p, h, 3'h1));
        pulse(0, ctl(1'b1, sd, 1'b0, p, h, 3'h1));
        if (w) pulse(2, t);
        if (!sd) ss_t <= 1'b0;
        repeat (4) @(posedge clk);
        #1 if (!sd) chk("miso drive", miso_oe_n, 8'h00);
        for (int i = 7; i >= 0; i--) begin
            if (!h) mosi_t = b[i];
            if (!h) cap[i] = miso_o;
            #6 sck_t = ~p;
            if (h) mosi_t = b[i];
            #6 if (h) cap[i] = miso_o;
            sck_t = p;
        end
        repeat (2) @(posedge clk);
        ss_t <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("slave rx", dat, b);
        chk("slave done", st & 8'h80, 8'h80);
        chk("slave tx", cap, e);
        if (!sd) chk("miso release", miso_oe_n, 8'h01);
        chk("gp free", gpf, sd);
        pulse(1, 8'h00);
        pulse(3, 8'h00);
    endtask : sxfer
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1 chk("ctl reset", ctl_q, spimsp_pkg::CTRL_RESET);
        chk("idle pins", {sck_oe_n, mosi_oe_n, mosi_o, miso_oe_n}, 8'h0F);
        for (int r = 1; r < 7; r++) begin
            seed = xs(seed);
            mxfer(r[2:0], r[0], r[1], seed[7:0], seed[15:8]);
        end
        mxfer(3'h1, 1'b0, 1'b0, 8'h80, 8'h01);
        $display("test master transfers ended");
        for (int r = 0; r < 8; r += 7) begin
            pulse(0, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, r[2:0]));
            edges = 0;
            pulse(2, 8'h5A);
            repeat (4) @(posedge clk);
            #1 chk("no start", {busy, edges[6:0]}, 8'h00);
        end
        pulse(0, ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h1));
        ss_t <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk("no fault", {st[4], gpf}, 16'h0001);
        pulse(0, ctl(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1));
        repeat (5) @(posedge clk);
        #1 chk("fault", {st[4], flt, ctl_q.module_enable_bit, ctl_q.master_select_bit}, 8'h0C);
        ss_t <= 1'b1;
        pulse(0, ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 3'h1));
        pulse(0, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1));
        #1 chk("fault kept", st & 8'h10, 8'h10);
        pulse(1, 8'h00);
        pulse(0, 8'h00);
        #1 chk("fault clear", st & 8'h10, 8'h00);
        $display("test mode fault ended");
        for (int f = 0; f < 4; f++) begin
            seed = xs(seed);
            sxfer(f[0], f[1], 1'b0, 1'b1, seed[7:0], seed[15:8], seed[15:8]);
        end
        sxfer(1'b0, 1'b1, 1'b1, 1'b1, 8'hC3, 8'h3C, 8'h3C);
        sxfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h96, 8'h00, 8'hC3);
        $display("test slave transfers ended");
        close_out();
    end
    initial begin
        // The whole run needs a few thousand cycles; allow several times that.
        #200000;
        mismatches++;
        close_out();
    end
endmodule : tb_top
